//--- core/irq_flag_mask.sv
/*
 Interrupt pending-flag and enable-mask pair with an AHB-Lite register
 slave, source routing, fixed priority pick and one level interrupt.
 Register words at byte offsets, data in the low bits:
   0x00 pending flags, read, write one to clear
   0x04 enable mask, read and write, bits 13..0
   0x08 shared-bit selection, read and write, bits 3..0
   0x0C winner status, read only: valid, priority, index
   0x10 acknowledge, any write clears the flag of the registered winner
   0x14 force, write one to set a flag
 Bit map, the same in flags and mask:
   0..2 external requests 0..2, 3 timer 0, 4 and 5 serial 0 receive and transmit
   6 unused or DMA 0, 7 timer 1 or DMA 1, 8 external request 3, 9 host port
   10 serial 1 receive or DMA 2, 11 serial 1 transmit or DMA 3, 12 DMA 4, 13 DMA 5
 Reads take one wait state and writes none. A flag sets three edges after
 its pin falls and one edge after a peripheral line rises.
 irq_o follows the flags and mask with no added lag.
 Assumes a single AHB-Lite master on clk_i, active-low external request
 pins from outside the clock domain, and peripheral requests on clk_i.
 Assumes word transfers; narrower writes are dropped.
 Assumes hready_i is this slave's own hreadyout_o.
*/
`timescale 1ns/1ns
`include "irq_flag_mask_params.svh"

module irq_flag_mask
    import irq_flag_mask_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic [3:0] ext_irq_n_i,
    input wire irq_sources_t periph_irq_i,
    output logic irq_o,
    output logic irq_valid_o,
    output logic [3:0] irq_index_o,
    output logic [4:0] irq_priority_o
);

    bus_phase_t phase_reg;
    bus_phase_t phase_next;
    logic [7:0] dp_addr_reg;
    logic [31:0] hrdata_reg;
    logic accept;
    logic wr_en;
    logic dp_word_reg;
    logic wr_flags;
    logic wr_mask;
    logic wr_select;
    logic wr_ack;
    logic wr_force;

    logic [3:0] ext_sync1_reg;
    logic [3:0] ext_sync2_reg;
    logic [3:0] ext_prev_reg;
    logic [3:0] ext_events;
    irq_sources_t periph_prev_reg;
    irq_sources_t periph_events;

    logic [15:0] set_vec;
    logic [15:0] flags_reg;
    logic [15:0] flags_next;
    logic [15:0] mask_reg;
    logic [`DMA_SELECT_WIDTH-1:0] dma_select_reg;
    logic [15:0] clear_vec;
    logic [15:0] force_vec;
    logic [15:0] enabled_vec;
    irq_winner_t winner;
    logic valid_reg;
    logic [3:0] index_reg;
    logic [4:0] priority_reg;

    // Lowest set bit wins; bit 0 is the most urgent
    function automatic irq_winner_t pick_winner(input logic [15:0] vec);
        irq_winner_t w;
        w.valid = 1'b0;
        w.index = 4'h0;
        for (int i = 13; i >= 0; i--) begin
            if (vec[i]) begin
                w.valid = 1'b1;
                w.index = 4'(i);
            end
        end
        return w;
    endfunction

    // One-hot of a bit index, used for acknowledge
    function automatic logic [15:0] index_onehot(input logic [3:0] idx);
        logic [15:0] v;
        v = 16'h0000;
        v[idx] = 1'b1;
        return v;
    endfunction

    // Write decode shared by every writable register
    function automatic logic wr_hit(input logic en,
                                    input logic [7:0] addr,
                                    input logic [7:0] ofs);
        return en && (addr == ofs);
    endfunction

    // Bus address phase taken only when the previous transfer is done
    assign accept = hsel_i & hready_i & htrans_i[1];

    always_comb begin
        phase_next = phase_reg;
        unique case (phase_reg)
            PH_IDLE, PH_WRITE, PH_READ_DONE: begin
                if (accept && hwrite_i) begin
                    phase_next = PH_WRITE;
                end else if (accept) begin
                    phase_next = PH_READ_WAIT;
                end else begin
                    phase_next = PH_IDLE;
                end
            end
            PH_READ_WAIT: begin
                phase_next = PH_READ_DONE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            phase_reg <= PH_IDLE;
        end else begin
            phase_reg <= phase_next;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dp_addr_reg <= 8'h00;
        end else if (accept) begin
            dp_addr_reg <= haddr_i[7:0];
        end
    end

    // Narrow writes are dropped rather than merged into a register word
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dp_word_reg <= 1'b0;
        end else if (accept) begin
            dp_word_reg <= (hsize_i == `HSIZE_WORD);
        end
    end

    // Wait state lets a read see a write from the transfer just before
    assign hreadyout_o = (phase_reg != PH_READ_WAIT);
    assign hresp_o = 1'b0;
    assign wr_en = (phase_reg == PH_WRITE) & dp_word_reg;
    // Strobes are one-hot by address, so clear and ack never collide
    assign wr_flags = wr_hit(wr_en, dp_addr_reg, `OFS_PENDING_FLAGS);
    assign wr_mask = wr_hit(wr_en, dp_addr_reg, `OFS_ENABLE_MASK);
    assign wr_select = wr_hit(wr_en, dp_addr_reg, `OFS_DMA_SELECT);
    assign wr_ack = wr_hit(wr_en, dp_addr_reg, `OFS_ACK);
    assign wr_force = wr_hit(wr_en, dp_addr_reg, `OFS_FORCE);

    function automatic logic [31:0] read_mux(input logic [7:0] addr,
                                             input logic [15:0] flags,
                                             input logic [15:0] mask,
                                             input logic [3:0] sel,
                                             input logic valid,
                                             input logic [3:0] idx,
                                             input logic [4:0] prio);
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (addr)
            `OFS_PENDING_FLAGS: d[15:0] = flags & `IRQ_USED_MASK;
            `OFS_ENABLE_MASK: d[15:0] = mask & `IRQ_USED_MASK;
            `OFS_DMA_SELECT: d[`DMA_SELECT_WIDTH-1:0] = sel;
            `OFS_WINNER_STATUS: begin
                d[`STATUS_VALID_BIT] = valid;
                d[`STATUS_PRIO_LSB +: 5] = prio;
                d[3:0] = idx;
            end
            default: d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (phase_reg == PH_READ_WAIT) begin
            hrdata_reg <= read_mux(dp_addr_reg, flags_reg, mask_reg, dma_select_reg,
                                   valid_reg, index_reg, priority_reg);
        end
    end

    assign hrdata_o = hrdata_reg;

    // Pins cross into clk_i through two flops before any use
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ext_sync1_reg <= 4'hF;
            ext_sync2_reg <= 4'hF;
        end else begin
            ext_sync1_reg <= ext_irq_n_i;
            ext_sync2_reg <= ext_sync1_reg;
        end
    end

    // Idle level after reset, so release makes no false edge
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ext_prev_reg <= 4'hF;
        end else begin
            ext_prev_reg <= ext_sync2_reg;
        end
    end

    // Falling edge of an active-low pin is one request
    genvar p;
    generate
        for (p = 0; p < 4; p++) begin : g_pin_edge
            assign ext_events[p] = ext_prev_reg[p] & ~ext_sync2_reg[p];
        end
    endgenerate

    // Rising edge only, so a held request does not refire after a clear
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            periph_prev_reg <= '0;
        end else begin
            periph_prev_reg <= periph_irq_i;
        end
    end

    assign periph_events = periph_irq_i & ~periph_prev_reg;

    irq_source_router u_router (
        .events_i(periph_events),
        .ext_events_i(ext_events),
        .dma_select_i(dma_select_reg),
        .set_vec_o(set_vec)
    );

    // Write-one-to-clear on flags, plus acknowledge of the current winner
    always_comb begin
        clear_vec = 16'h0000;
        if (wr_flags) begin
            clear_vec = hwdata_i[15:0];
        end
        // Ack uses the registered winner, one cycle stale at worst
        if (wr_ack && valid_reg) begin
            clear_vec = index_onehot(index_reg);
        end
    end

    // Force sets flags like a source would, handy for software tests
    always_comb begin
        force_vec = 16'h0000;
        if (wr_force) begin
            force_vec = hwdata_i[15:0];
        end
    end

    // A new event in the clearing cycle is kept: set wins
    assign flags_next = ((flags_reg & ~clear_vec) | set_vec | force_vec) & `IRQ_USED_MASK;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flags_reg <= `FLAGS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // Bit 6 stays writable while it has no source
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mask_reg <= `MASK_RESET;
        end else if (wr_mask) begin
            mask_reg <= hwdata_i[15:0] & `IRQ_USED_MASK;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dma_select_reg <= `DMA_SELECT_RESET;
        end else if (wr_select) begin
            dma_select_reg <= hwdata_i[`DMA_SELECT_WIDTH-1:0];
        end
    end

    assign enabled_vec = flags_reg & mask_reg;
    assign winner = pick_winner(enabled_vec);

    // Winner registered so vector outputs come from flops
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= winner.valid;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            index_reg <= 4'h0;
        end else begin
            index_reg <= winner.index;
        end
    end

    // Priority kept beside the index so readers need no adder
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            priority_reg <= 5'h00;
        end else begin
            priority_reg <= 5'(winner.index) + `PRIORITY_BASE;
        end
    end

    // Level output straight from the two registers, no extra lag
    assign irq_o = |enabled_vec;
    assign irq_valid_o = valid_reg;
    assign irq_index_o = index_reg;
    assign irq_priority_o = priority_reg;

endmodule

//--- core/irq_flag_mask_params.svh
/*
 Constants for the interrupt flag and mask pair: register offsets, bit
 positions of every source, reset values and field layouts.
 Assumes inclusion by bare name from design files only.
*/
`ifndef IRQ_FLAG_MASK_PARAMS_SVH
`define IRQ_FLAG_MASK_PARAMS_SVH

// Byte offsets on the register bus
`define OFS_PENDING_FLAGS 8'h00
`define OFS_ENABLE_MASK 8'h04
`define OFS_DMA_SELECT 8'h08
`define OFS_WINNER_STATUS 8'h0C
`define OFS_ACK 8'h10
`define OFS_FORCE 8'h14

// Transfer size code of a whole word
`define HSIZE_WORD 3'h2

// Bit positions, same in flags and mask
`define BIT_EXT0 4'h0
`define BIT_EXT1 4'h1
`define BIT_EXT2 4'h2
`define BIT_TIMER0 4'h3
`define BIT_SERIAL0_RX 4'h4
`define BIT_SERIAL0_TX 4'h5
`define BIT_SHARED6 4'h6
`define BIT_SHARED7 4'h7
`define BIT_EXT3 4'h8
`define BIT_HOST_PORT 4'h9
`define BIT_SHARED10 4'hA
`define BIT_SHARED11 4'hB
`define BIT_DMA4 4'hC
`define BIT_DMA5 4'hD

// Bits 15..14 never hold a source
`define IRQ_USED_MASK 16'h3FFF
`define FLAGS_RESET 16'h0000
`define MASK_RESET 16'h0000
`define DMA_SELECT_RESET 4'h0
`define DMA_SELECT_WIDTH 4

// Lowest bit has priority 3, bit 13 has 16
`define PRIORITY_BASE 5'h03
`define STATUS_VALID_BIT 9
`define STATUS_PRIO_LSB 4

`endif

//--- core/irq_flag_mask_pkg.sv
/*
 Types for the interrupt flag and mask pair.
 Assumes the constants header is included where offsets are needed.
*/
package irq_flag_mask_pkg;

    typedef struct packed {
        logic [5:0] dma_ch_irq;
        logic host_port_irq;
        logic serial1_tx_irq;
        logic serial1_rx_irq;
        logic serial0_tx_irq;
        logic serial0_rx_irq;
        logic timer1_irq;
        logic timer0_irq;
    } irq_sources_t;

    typedef struct packed {
        logic valid;
        logic [3:0] index;
    } irq_winner_t;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_WRITE = 2'b01,
        PH_READ_WAIT = 2'b11,
        PH_READ_DONE = 2'b10
    } bus_phase_t;

endpackage

//--- core/irq_source_router.sv
/*
 Routes source events onto flag bit positions, including the four shared
 positions steered by the DMA selection bits.
 Assumes one-cycle event pulses on the system clock.
*/
`timescale 1ns/1ns
`include "irq_flag_mask_params.svh"

module irq_source_router
    import irq_flag_mask_pkg::*;
(
    input wire irq_sources_t events_i,
    input wire logic [3:0] ext_events_i,
    input wire logic [`DMA_SELECT_WIDTH-1:0] dma_select_i,
    output logic [15:0] set_vec_o
);

    logic [3:0] default_src;
    logic [3:0] dma_src;
    logic [3:0] shared_bits;

    // Bit 6 has no default source
    assign default_src = {events_i.serial1_tx_irq, events_i.serial1_rx_irq, events_i.timer1_irq, 1'b0};
    assign dma_src = events_i.dma_ch_irq[3:0];

    genvar g;
    generate
        for (g = 0; g < `DMA_SELECT_WIDTH; g++) begin : g_shared
            assign shared_bits[g] = dma_select_i[g] ? dma_src[g] : default_src[g];
        end
    endgenerate

    always_comb begin
        set_vec_o = 16'h0000;
        set_vec_o[`BIT_EXT0] = ext_events_i[0];
        set_vec_o[`BIT_EXT1] = ext_events_i[1];
        set_vec_o[`BIT_EXT2] = ext_events_i[2];
        set_vec_o[`BIT_TIMER0] = events_i.timer0_irq;
        set_vec_o[`BIT_SERIAL0_RX] = events_i.serial0_rx_irq;
        set_vec_o[`BIT_SERIAL0_TX] = events_i.serial0_tx_irq;
        set_vec_o[`BIT_SHARED6] = shared_bits[0];
        set_vec_o[`BIT_SHARED7] = shared_bits[1];
        set_vec_o[`BIT_EXT3] = ext_events_i[3];
        set_vec_o[`BIT_HOST_PORT] = events_i.host_port_irq;
        set_vec_o[`BIT_SHARED10] = shared_bits[2];
        set_vec_o[`BIT_SHARED11] = shared_bits[3];
        set_vec_o[`BIT_DMA4] = events_i.dma_ch_irq[4];
        set_vec_o[`BIT_DMA5] = events_i.dma_ch_irq[5];
    end

endmodule

//--- tb/irq_src_model.sv
/*
 Far side model: peripheral request lines and external request pins.
 Assumes requests from the bench on clk_i; pins idle high.
*/
`timescale 1ns/1ns

module irq_src_model
    import irq_flag_mask_pkg::*;
(
    input wire logic clk_i,
    input wire irq_sources_t pulse_i,
    input wire logic [3:0] pin_i,
    output irq_sources_t periph_o,
    output logic [3:0] ext_irq_n_o
);
    initial periph_o = '0;
    initial ext_irq_n_o = 4'hF;
    // Registered so every edge lands just after a clock edge
    always @(posedge clk_i) begin
        periph_o <= pulse_i;
        ext_irq_n_o <= ~pin_i;
    end
endmodule

//--- tb/irq_flag_mask_monitor.sv
/*
 Concurrent checks on the top ports of the flag and mask pair.
 Assumes a single clock domain and hready tied to hreadyout.
*/
`timescale 1ns/1ns

module irq_flag_mask_monitor (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic irq_o,
    input wire logic irq_valid_o,
    input wire logic [3:0] irq_index_o,
    input wire logic [4:0] irq_priority_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    resp_okay_a: assert property (hresp_o == 1'b0) else $error("response not okay");
    read_wait_a: assert property (hsel_i && hready_i && htrans_i[1] && !hwrite_i
        |=> !hreadyout_o ##1 hreadyout_o) else $error("read wait state wrong");
    write_nowait_a: assert property (hsel_i && hready_i && htrans_i[1] && hwrite_i
        |=> hreadyout_o) else $error("write stalled");
    data_holds_a: assert property ($past(hreadyout_o) |-> $stable(hrdata_o)) else $error("read data moved");
    valid_follows_a: assert property (irq_valid_o == $past(irq_o)) else $error("valid not one cycle behind");
    prio_offset_a: assert property (irq_valid_o |-> irq_priority_o == irq_index_o + 5'h03)
        else $error("priority not index plus three");
    index_range_a: assert property (irq_valid_o |-> irq_index_o <= 4'hD) else $error("reserved index won");
    idle_quiet_a: assert property (!irq_valid_o |-> irq_index_o == 4'h0 || $past(irq_valid_o))
        else $error("index without request");
endmodule

//--- tb/tb_top.sv
/*
 Self-checking bench for the flag and mask pair, AHB-Lite master tasks.
 Assumes the model drives the request lines; seed fixed.
*/
`timescale 1ns/1ns

module tb_top;
    import irq_flag_mask_pkg::*;
    logic clk_i = 1'b0, reset_n_i = 1'b0, hsel = 1'b0, hwrite = 1'b0, rdy, resp, irq, vld;
    logic [31:0] haddr = '0, hwdata = '0, rdata, rq;
    logic [1:0] htrans = 2'h0;
    logic [3:0] idx, pins = 4'h0, ext_n, sel;
    logic [4:0] prio;
    logic [15:0] f, m, e;
    irq_sources_t pulse = '0, periph;
    int bad_count = 0, samples_checked = 0, n;
    always #5 clk_i = ~clk_i;
    irq_src_model i_model (.clk_i(clk_i), .pulse_i(pulse), .pin_i(pins), .periph_o(periph), .ext_irq_n_o(ext_n));
    irq_flag_mask i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(rdy), .hrdata_o(rdata), .hreadyout_o(rdy),
        .hresp_o(resp), .ext_irq_n_i(ext_n), .periph_irq_i(periph), .irq_o(irq), .irq_valid_o(vld),
        .irq_index_o(idx), .irq_priority_o(prio));
    task automatic give_verdict();
        if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x) begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, g, x);
        end
    endtask
    // Ready is looked at before the edge so the sample never races the flop
    task automatic wt();
        logic ok;
        int k;
        k = 0;
        do begin
            @(negedge clk_i);
            ok = rdy;
            rq = rdata;
            @(posedge clk_i);
            k++;
        end while (ok !== 1'b1 && k < 20);
        if (ok !== 1'b1) begin
            $display("wrong value at %0t: bus wait timed out", $time);
            bad_count++;
            give_verdict();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        wt();
        htrans <= 2'h0;
        hwdata <= d;
        wt();
    endtask
    function automatic logic [15:0] expf(int i, logic [3:0] s);
        case (i)
            0: expf = 16'h0008;
            1: expf = s[1] ? 16'h0000 : 16'h0080;
            2: expf = 16'h0010;
            3: expf = 16'h0020;
            4: expf = s[2] ? 16'h0000 : 16'h0400;
            5: expf = s[3] ? 16'h0000 : 16'h0800;
            6: expf = 16'h0200;
            7: expf = s[0] ? 16'h0040 : 16'h0000;
            8: expf = s[1] ? 16'h0080 : 16'h0000;
            9: expf = s[2] ? 16'h0400 : 16'h0000;
            10: expf = s[3] ? 16'h0800 : 16'h0000;
            default: expf = i == 11 ? 16'h1000 : 16'h2000;
        endcase
    endfunction
    initial begin
        n = $urandom(23717);
        repeat (8) @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        for (int j = 0; j < 3; j++) begin
            bus(1'b0, 8'(j * 4), 32'h0);
            chk(rq, 32'h0);
        end
        bus(1'b0, 8'h40, 32'h0);
        chk(rq, 32'h0);
        for (int p = 0; p < 3; p++) begin
            sel = p == 0 ? 4'h0 : p == 1 ? 4'hF : 4'($urandom);
            bus(1'b1, 8'h08, {28'h0, sel});
            bus(1'b0, 8'h08, 32'h0);
            chk(rq, {28'h0, sel});
            for (int i = 0; i < 13; i++) begin
                pulse <= irq_sources_t'(13'h1 << i);
                @(posedge clk_i);
                pulse <= '0;
                repeat (3) @(posedge clk_i);
                bus(1'b0, 8'h00, 32'h0);
                chk(rq, {16'h0, expf(i, sel)});
                bus(1'b1, 8'h00, 32'hFFFF);
            end
        end
        for (int i = 0; i < 4; i++) begin
            pins <= 4'h1 << i;
            repeat (4) @(posedge clk_i);
            pins <= 4'h0;
            repeat (4) @(posedge clk_i);
            bus(1'b0, 8'h00, 32'h0);
            chk(rq, i == 3 ? 32'h0100 : 32'h1 << i);
            bus(1'b1, 8'h00, 32'hFFFF);
        end
        for (int r = 0; r < 24; r++) begin
            f = 16'($urandom);
            m = r == 0 ? 16'hFFFF : 16'($urandom);
            e = f & m & 16'h3FFF;
            bus(1'b1, 8'h04, {16'h0, m});
            bus(1'b1, 8'h14, {16'h0, f});
            @(negedge clk_i);
            chk(irq, |e);
            @(posedge clk_i);
            @(negedge clk_i);
            n = 0;
            while (n < 14 && !e[n]) n++;
            chk({vld, idx, prio}, |e ? {1'b1, 4'(n), 5'(n + 3)} : 10'h0);
            @(posedge clk_i);
            bus(1'b0, 8'h0C, 32'h0);
            chk(rq, |e ? {22'h0, 1'b1, 5'(n + 3), 4'(n)} : 32'h0);
            bus(1'b1, 8'h10, 32'h0);
            bus(1'b0, 8'h04, 32'h0);
            chk(rq, {16'h0, m & 16'h3FFF});
            bus(1'b0, 8'h00, 32'h0);
            chk(rq, {16'h0, f & 16'h3FFF & ~(|e ? 16'h1 << n : 16'h0)});
            bus(1'b1, 8'h00, 32'hFFFF);
        end
        give_verdict();
    end
endmodule

bind irq_flag_mask irq_flag_mask_monitor i_mon (.clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .irq_o(irq_o), .irq_valid_o(irq_valid_o), .irq_index_o(irq_index_o),
    .irq_priority_o(irq_priority_o));
